// ---- src/ubre_top.sv ----
// usb device bus reset detection and exit to connected
//
// Function
// - after bus reset, wait 800 us continuous J-state before connecting.
// - packets from host are dropped until the connected state is reached.
// - any non-idle line activity during the wait restarts the idle period.
// - fixed revision connects right after bus reset, no idle period needed.
// - debug override forces receive view to dp=1, dm=0, a J-state.
`timescale 1ns/1ns
module ubre_top #(
  parameter int unsigned P_RESET_CYC = ubre_pkg::UBRE_RESET_SE0_CYC,
  parameter int unsigned P_IDLE_CYC = ubre_pkg::UBRE_IDLE_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_dp,
  input wire logic i_dm,
  input wire logic i_force_j,
  input wire logic i_fixed_rev,
  input wire logic i_pkt_valid,
  output logic o_connected,
  output logic o_in_reset,
  output logic o_pkt_accept
);

  // ************************************************************
  // receive view and line decode
  // ************************************************************
  ubre_pkg::ubre_pins_s rx_view;
  ubre_pkg::ubre_line_e line_st;
  ubre_pkg::ubre_state_e state_reg;
  ubre_pkg::ubre_state_e state_next;
  logic connected_reg;
  logic in_reset_reg;
  logic accept_reg;
  wire logic is_se0;
  wire logic is_j;
  wire logic se0_done;
  wire logic idle_done;
  wire logic waiting;

  // override mux only models its effect; real pins are ignored while set
  assign rx_view.dp = i_force_j ? 1'b1 : i_dp;
  assign rx_view.dm = i_force_j ? 1'b0 : i_dm;
  assign line_st = (!rx_view.dp && !rx_view.dm) ? ubre_pkg::UBRE_LS_SE0 :
                   ( rx_view.dp && !rx_view.dm) ? ubre_pkg::UBRE_LS_J :
                   (!rx_view.dp &&  rx_view.dm) ? ubre_pkg::UBRE_LS_K : ubre_pkg::UBRE_LS_SE1;
  assign is_se0 = (line_st == ubre_pkg::UBRE_LS_SE0);
  assign is_j = (line_st == ubre_pkg::UBRE_LS_J);
  assign waiting = (state_reg == ubre_pkg::UBRE_ST_IDLE_WAIT);

  // ************************************************************
  // timers
  // ************************************************************
  // se0 duration; reset detect as soon as the host's full 10 ms elapses
  ubre_idle_counter #(
    .P_LIMIT(P_RESET_CYC[17:0])
  ) u_se0_cnt (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_restart(!is_se0),
    .i_run(1'b1),
    .o_done(se0_done)
  );

  // forced J from software counts as idle too, which is what lets it work
  ubre_idle_counter #(
    .P_LIMIT(P_IDLE_CYC[17:0])
  ) u_idle_cnt (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_restart(!is_j || !waiting),
    .i_run(waiting),
    .o_done(idle_done)
  );

  // ************************************************************
  // reset state machine
  // ************************************************************
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ubre_pkg::UBRE_ST_CONNECTED:
        if (se0_done)
          state_next = ubre_pkg::UBRE_ST_IN_RESET;
      ubre_pkg::UBRE_ST_IN_RESET:
        if (!is_se0)
          state_next = i_fixed_rev ? ubre_pkg::UBRE_ST_CONNECTED : ubre_pkg::UBRE_ST_IDLE_WAIT;
      ubre_pkg::UBRE_ST_IDLE_WAIT:
        if (is_se0 && se0_done)
          state_next = ubre_pkg::UBRE_ST_IN_RESET;
        else if (i_fixed_rev || idle_done)
          state_next = ubre_pkg::UBRE_ST_CONNECTED;
      default:
        state_next = ubre_pkg::UBRE_ST_IN_RESET;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state_reg <= ubre_pkg::UBRE_ST_IN_RESET;
      connected_reg <= 1'b0;
      in_reset_reg <= 1'b1;
      accept_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      connected_reg <= (state_next == ubre_pkg::UBRE_ST_CONNECTED);
      in_reset_reg <= (state_next != ubre_pkg::UBRE_ST_CONNECTED);
      // a packet is taken only in a cycle already connected
      accept_reg <= i_pkt_valid && (state_reg == ubre_pkg::UBRE_ST_CONNECTED);
    end
  end

  assign o_connected = connected_reg;
  assign o_in_reset = in_reset_reg;
  assign o_pkt_accept = accept_reg;

endmodule : ubre_top

// ---- src/ubre_pkg.sv ----
// package for the usb bus reset exit block
package ubre_pkg;

  // ************************************************************
  // line states and timing
  // ************************************************************
  typedef enum logic [1:0] {
    UBRE_LS_SE0,
    UBRE_LS_J,
    UBRE_LS_K,
    UBRE_LS_SE1
  } ubre_line_e;

  typedef enum logic [1:0] {
    UBRE_ST_CONNECTED,
    UBRE_ST_IN_RESET,
    UBRE_ST_IDLE_WAIT
  } ubre_state_e;

  typedef struct packed {
    logic dp;
    logic dm;
  } ubre_pins_s;

  localparam int unsigned UBRE_CLK_HZ = 20_000_000;
  localparam int unsigned UBRE_RESET_SE0_MS = 10;
  localparam int unsigned UBRE_IDLE_US = 800;
  localparam int unsigned UBRE_IDLE_CYC = (UBRE_IDLE_US * (UBRE_CLK_HZ / 1_000_000));
  localparam int unsigned UBRE_RESET_SE0_CYC = (UBRE_RESET_SE0_MS * (UBRE_CLK_HZ / 1000));
  localparam int unsigned UBRE_CNT_W = 18;

endpackage : ubre_pkg

// ---- src/ubre_idle_counter.sv ----
// saturating idle-time counter with restart
`timescale 1ns/1ns
module ubre_idle_counter #(
  parameter logic [17:0] P_LIMIT = 18'h0_0001
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_restart,
  input wire logic i_run,
  output logic o_done
);

  logic [17:0] cnt_reg;
  logic [17:0] cnt_next;
  wire logic at_limit;

  assign at_limit = (cnt_reg >= P_LIMIT);
  assign cnt_next = i_restart ? 18'h0_0000 : (i_run && !at_limit) ? (cnt_reg + 18'h0_0001) : cnt_reg;
  assign o_done = at_limit && !i_restart;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      cnt_reg <= 18'h0_0000;
    else
      cnt_reg <= cnt_next;
  end

endmodule : ubre_idle_counter

// ---- dv/ubre_host_model.sv ----
// behavioural usb host driving the line pair
`timescale 1ns/1ns
module ubre_host_model (
  input wire logic [1:0] i_line,
  output ubre_pkg::ubre_pins_s o_pins
);
  // ****
  // line state to pin levels
  // ****
  // host never releases the pair here; a long se0 is its bus reset
  assign o_pins = ubre_pkg::ubre_pins_s'({i_line[0], i_line[1]});
endmodule : ubre_host_model

// ---- dv/ubre_top_checker.sv ----
// checker for the bus reset exit block
`timescale 1ns/1ns
module ubre_top_checker #(
  parameter int unsigned P_IDLE_CYC = 10
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_dp,
  input wire logic i_dm,
  input wire logic i_force_j,
  input wire logic i_fixed_rev,
  input wire logic i_pkt_valid,
  input wire logic o_connected,
  input wire logic o_in_reset,
  input wire logic o_pkt_accept
);
  // ****
  // idle run as the receive path sees it
  // ****
  logic [17:0] j_run_reg;
  wire logic j_now = i_force_j | (i_dp & ~i_dm);
  always_ff @(posedge i_clk)
    j_run_reg <= (i_rst_n & j_now) ? j_run_reg + 18'h0_0001 : 18'h0_0000;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  chk_idle_connect: assert property (
    $rose(o_connected) && !$past(i_fixed_rev) |-> j_run_reg >= P_IDLE_CYC) else $error("early connect");
  chk_busy_holds: assert property (
    o_in_reset && !i_fixed_rev && !j_now |=> o_in_reset) else $error("left reset on traffic");
  chk_fixed_fast: assert property (
    o_in_reset && i_fixed_rev && j_now |=> o_connected) else $error("fixed rev slow");
  chk_accept_cause: assert property (
    o_pkt_accept |-> $past(i_pkt_valid) && $past(o_connected)) else $error("bad accept");
  chk_accept_given: assert property (
    i_pkt_valid && o_connected |=> o_pkt_accept) else $error("lost packet");
  chk_state_pair: assert property (
    o_in_reset != o_connected) else $error("state outputs disagree");
  cover property ($rose(o_connected) && i_fixed_rev);
  cover property ($fell(o_connected));
  cover property (o_pkt_accept);
endmodule : ubre_top_checker
bind ubre_top ubre_top_checker #(.P_IDLE_CYC(P_IDLE_CYC)) u_chk (.i_clk, .i_rst_n, .i_dp, .i_dm,
  .i_force_j, .i_fixed_rev, .i_pkt_valid, .o_connected, .o_in_reset, .o_pkt_accept);

// ---- dv/ubre_top_bench.sv ----
// self-checking bench for the bus reset exit block
`timescale 1ns/1ns
module ubre_top_bench;
  // ****
  // stimulus rows: line, force, fixed, cycles, connected
  // ****
  typedef struct packed {logic [1:0] ln; logic f; logic x; logic [7:0] n; logic c;} ubre_row_s;
  // short idle, k restart, short again, full idle, bus reset, forced j, release, fixed rev
  ubre_row_s rows [8] = '{'{2'h1, 0, 0, 8'h05, 0}, '{2'h2, 0, 0, 8'h01, 0}, '{2'h1, 0, 0, 8'h08, 0},
    '{2'h1, 0, 0, 8'h06, 1}, '{2'h0, 0, 0, 8'h19, 0}, '{2'h0, 1, 0, 8'h0f, 1},
    '{2'h0, 0, 0, 8'h19, 0}, '{2'h1, 0, 1, 8'h03, 1}};
  logic clk = 0, rst_n = 0, frc = 0, fix = 0, pv = 0;
  logic [1:0] line = 2'h1;
  ubre_pkg::ubre_pins_s pins;
  wire logic conn, in_rst, acc;
  int err_count = 0, cmp_count = 0, cyc = 0;
  always #25 clk = ~clk;
  ubre_host_model host (.i_line(line), .o_pins(pins));
  ubre_top #(.P_RESET_CYC(20), .P_IDLE_CYC(10)) uut (.i_clk(clk), .i_rst_n(rst_n), .i_dp(pins.dp),
    .i_dm(pins.dm), .i_force_j(frc), .i_fixed_rev(fix), .i_pkt_valid(pv), .o_connected(conn),
    .o_in_reset(in_rst), .o_pkt_accept(acc));
  task automatic chk(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask : chk
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results
  // hang guard well above the roughly 110 cycles the tests need
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      err_count++;
      results();
    end
  end
  initial
  begin
    repeat (4) @(posedge clk);
    #1 chk("in_reset", 1, in_rst);
    @(posedge clk) rst_n <= 1;
    foreach (rows[i])
    begin
      @(posedge clk) line <= rows[i].ln;
      frc <= rows[i].f;
      fix <= rows[i].x;
      repeat (rows[i].n) @(posedge clk);
      #1 chk("connected", rows[i].c, conn);
    end
    @(posedge clk) pv <= 1;
    repeat (2)
    begin
      @(posedge clk);
      #1 chk("accept", 1, acc);
    end
    // mid-run reset with packets still arriving
    @(posedge clk) rst_n <= 0;
    fix <= 0;
    @(posedge clk) rst_n <= 1;
    repeat (5) @(posedge clk);
    #1 chk("accept", 0, acc);
    results();
  end
endmodule : ubre_top_bench
